// >>> dat_link_pwr_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// link power controller stand-in
// ----------------------------------------
module dat_link_pwr_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // response speed, 1 stretches settling
  input wire logic slow,
  // handshake
  input wire logic power_up_request,
  output logic power_up_acknowledge
);
  logic [3:0] wait_r;
  // ack drops with the request so a stale ack never lingers
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !power_up_request)
    begin
      wait_r <= 4'h0;
      power_up_acknowledge <= 1'b0;
    end
    else if (wait_r == (slow ? 4'h9 : 4'h2))
      power_up_acknowledge <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end
endmodule : dat_link_pwr_model
`default_nettype wire

// >>> dat_pkg.sv
// ----------------------------------------
// register map and field layout
// ----------------------------------------
package dat_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 8;

  // register byte offsets (no offsets printed; chosen locally)
  localparam logic [5:0] OFS_DBG_AUTH = 6'h00;
  localparam logic [5:0] OFS_TRIG_U0 = 6'h04;
  localparam logic [5:0] OFS_TRIG_U1 = 6'h08;
  localparam logic [5:0] OFS_TRIG_GRP = 6'h0C;
  localparam logic [5:0] OFS_WDOG_MGMT = 6'h10;
  localparam logic [5:0] OFS_WDOG_SYS = 6'h14;
  localparam logic [5:0] OFS_DBG_EXP = 6'h18;
  localparam logic [5:0] OFS_SER_PWR = 6'h1C;
  localparam logic [5:0] OFS_COH_PWR = 6'h20;

  // field positions
  localparam int unsigned POS_SNID = 2;
  localparam int unsigned POS_SID = 1;
  localparam int unsigned POS_GEXT = 0;
  localparam int unsigned POS_REQ = 0;
  localparam int unsigned POS_ACK = 1;
  localparam int unsigned LSB_NID_SEL = 0;
  localparam int unsigned LSB_DBG_SEL = 8;
  localparam int unsigned LSB_U2_NID_SEL = 16;
  localparam int unsigned LSB_U2_DBG_SEL = 24;

  // reset values
  localparam logic [2:0] RST_DBG_AUTH = 3'h7;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic RST_REQ = 1'b0;

  // one cross-trigger unit's pair of selects
  typedef struct packed {
    logic [7:0] debug_enable_trigger_select;
    logic [7:0] noninvasive_trigger_select;
  } dat_trig_sel_type;

  // debug authentication enables
  typedef struct packed {
    logic secure_noninvasive_debug_en;
    logic secure_invasive_debug_en;
    logic global_external_debug_en;
  } dat_auth_type;

  // register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [31:0] wdata;
  } dat_req_type;

endpackage : dat_pkg

// >>> dat_power_handshake.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// one link power request/acknowledge pair
// ----------------------------------------
module dat_power_handshake
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // software side
  input wire logic wr_en,
  input wire logic wr_req,
  output logic [31:0] rd_val,
  // link side
  output logic power_up_request,
  input wire logic power_up_acknowledge
);

  logic req_r;
  logic req_nxt;
  logic ack_r;

  // request holds until software rewrites it
  assign req_nxt = wr_en ? wr_req : req_r;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      req_r <= dat_pkg::RST_REQ;
      ack_r <= 1'b0;
    end
    else
    begin
      req_r <= req_nxt;
      ack_r <= power_up_acknowledge;
    end
  end

  assign power_up_request = req_r;

  // ack bit is status only; reserved bits zero
  always_comb
  begin
    rd_val = '0;
    rd_val[dat_pkg::POS_REQ] = req_r;
    rd_val[dat_pkg::POS_ACK] = ack_r;
  end

endmodule : dat_power_handshake

`default_nettype wire

// >>> dat_regs.sv
// What this block does
// [RULE_01] bit 2 of debug authentication drives secure non-invasive enable, reset 1.
// [RULE_02] bit 1 of debug authentication drives secure invasive enable, reset 1.
// [RULE_03] bit 0 drives global external debug enable, reset 1; bits 31:3 reserved.
// [RULE_04] bits 15:8 of each general trigger mask drive debug-enable select, reset 0.
// [RULE_05] bits 7:0 of each general trigger mask drive non-invasive select, reset 0.
// [RULE_06] watchdog trigger masks hold only the 15:8 debug-enable select.
// [RULE_07] debug expansion mask drives two units with four bytes, all reset 0.
// [RULE_08] serial link power bit 0 is a request written by software, reset 0.
// [RULE_09] serial link power bit 1 shows the link acknowledge, reset 0.
// [RULE_10] serial link acknowledge bit is read-only, writes to it ignored.
// [RULE_11] coherent link power bit 0 is a request written by software, reset 0.
// [RULE_12] coherent link power bit 1 shows its acknowledge read-only, reset 0.
// [RULE_13] authentication and trigger masks accept access at any time.
// [RULE_14] reserved bits read zero and ignore writes.
// [RULE_15] power controllers acknowledge only after a request; request holds.
`timescale 1ns/100ps
`default_nettype none

module dat_regs
#(
  parameter int unsigned NUM_GEN = 3
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register access
  input wire dat_pkg::dat_req_type reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // debug authentication
  output dat_pkg::dat_auth_type auth_en,
  // general cross-trigger units 0, 1 and group
  output dat_pkg::dat_trig_sel_type [NUM_GEN-1:0] gen_trig_sel,
  // watchdog cross-trigger units
  output logic [7:0] mgmt_wdog_debug_enable_select,
  output logic [7:0] sys_wdog_debug_enable_select,
  // debug expansion units
  output logic [7:0] unit_one_debug_enable_select,
  output logic [7:0] unit_one_noninvasive_select,
  output logic [7:0] unit_two_debug_enable_select,
  output logic [7:0] unit_two_noninvasive_select,
  // link power handshakes
  output logic serial_power_up_request,
  input wire logic serial_power_up_acknowledge,
  output logic coherent_power_up_request,
  input wire logic coherent_power_up_acknowledge
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [7:0] byte_at(input logic [31:0] d,
                                         input int unsigned lsb);
    byte_at = d[lsb +: 8];
  endfunction : byte_at

  wire logic wr = reg_req.wr;
  wire logic [5:0] a = reg_req.addr;
  wire logic [31:0] wd = reg_req.wdata;

  wire logic wr_auth = wr && hit(a, dat_pkg::OFS_DBG_AUTH);
  wire logic wr_u0 = wr && hit(a, dat_pkg::OFS_TRIG_U0);
  wire logic wr_u1 = wr && hit(a, dat_pkg::OFS_TRIG_U1);
  wire logic wr_grp = wr && hit(a, dat_pkg::OFS_TRIG_GRP);
  wire logic wr_wm = wr && hit(a, dat_pkg::OFS_WDOG_MGMT);
  wire logic wr_ws = wr && hit(a, dat_pkg::OFS_WDOG_SYS);
  wire logic wr_exp = wr && hit(a, dat_pkg::OFS_DBG_EXP);
  wire logic wr_ser = wr && hit(a, dat_pkg::OFS_SER_PWR);
  wire logic wr_coh = wr && hit(a, dat_pkg::OFS_COH_PWR);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  dat_pkg::dat_auth_type auth_r;
  dat_pkg::dat_trig_sel_type gen_r [NUM_GEN];
  logic [7:0] wm_r;
  logic [7:0] ws_r;
  dat_pkg::dat_trig_sel_type exp1_r;
  dat_pkg::dat_trig_sel_type exp2_r;
  logic [NUM_GEN-1:0] wr_gen;

  assign wr_gen[0] = wr_u0;
  assign wr_gen[1] = wr_u1;
  assign wr_gen[2] = wr_grp;

  // no access restrictions: writes land whenever decoded; see [RULE_13]
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      auth_r <= dat_pkg::RST_DBG_AUTH; // see [RULE_01]
    else if (wr_auth)
    begin
      auth_r.secure_noninvasive_debug_en <= wd[dat_pkg::POS_SNID]; // see [RULE_01]
      auth_r.secure_invasive_debug_en <= wd[dat_pkg::POS_SID]; // see [RULE_02]
      auth_r.global_external_debug_en <= wd[dat_pkg::POS_GEXT]; // see [RULE_03]
    end
  end

  for (genvar g = 0; g < NUM_GEN; g++)
  begin : g_gen
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
      begin
        gen_r[g].debug_enable_trigger_select <= dat_pkg::RST_SEL; // see [RULE_04]
        gen_r[g].noninvasive_trigger_select <= dat_pkg::RST_SEL; // see [RULE_05]
      end
      else if (wr_gen[g])
      begin
        gen_r[g].debug_enable_trigger_select <=
          byte_at(wd, dat_pkg::LSB_DBG_SEL); // see [RULE_04]
        gen_r[g].noninvasive_trigger_select <=
          byte_at(wd, dat_pkg::LSB_NID_SEL); // see [RULE_05]
      end
    end
    assign gen_trig_sel[g] = gen_r[g];
  end

  // watchdog units only have the upper select byte
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wm_r <= dat_pkg::RST_SEL; // see [RULE_06]
      ws_r <= dat_pkg::RST_SEL;
    end
    else
    begin
      if (wr_wm)
        wm_r <= byte_at(wd, dat_pkg::LSB_DBG_SEL); // see [RULE_06]
      if (wr_ws)
        ws_r <= byte_at(wd, dat_pkg::LSB_DBG_SEL); // see [RULE_06]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      exp1_r <= '0; // see [RULE_07]
      exp2_r <= '0;
    end
    else if (wr_exp)
    begin
      exp2_r.debug_enable_trigger_select <=
        byte_at(wd, dat_pkg::LSB_U2_DBG_SEL); // see [RULE_07]
      exp2_r.noninvasive_trigger_select <= byte_at(wd, dat_pkg::LSB_U2_NID_SEL);
      exp1_r.debug_enable_trigger_select <= byte_at(wd, dat_pkg::LSB_DBG_SEL);
      exp1_r.noninvasive_trigger_select <= byte_at(wd, dat_pkg::LSB_NID_SEL);
    end
  end

  assign auth_en = auth_r;
  assign mgmt_wdog_debug_enable_select = wm_r;
  assign sys_wdog_debug_enable_select = ws_r;
  assign unit_one_debug_enable_select = exp1_r.debug_enable_trigger_select;
  assign unit_one_noninvasive_select = exp1_r.noninvasive_trigger_select;
  assign unit_two_debug_enable_select = exp2_r.debug_enable_trigger_select;
  assign unit_two_noninvasive_select = exp2_r.noninvasive_trigger_select;

  // ----------------------------------------
  // link power
  // ----------------------------------------
  logic [31:0] ser_rd;
  logic [31:0] coh_rd;

  // request driven as written; ack only sampled; see [RULE_08]
  dat_power_handshake u_ser_pwr
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(wr_ser),
    .wr_req(wd[dat_pkg::POS_REQ]), // see [RULE_10]
    .rd_val(ser_rd), // see [RULE_09]
    .power_up_request(serial_power_up_request),
    .power_up_acknowledge(serial_power_up_acknowledge)
  );

  // same handshake for the coherent link; see [RULE_11]
  dat_power_handshake u_coh_pwr
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(wr_coh),
    .wr_req(wd[dat_pkg::POS_REQ]),
    .rd_val(coh_rd), // see [RULE_12]
    .power_up_request(coherent_power_up_request),
    .power_up_acknowledge(coherent_power_up_acknowledge)
  );

  // ----------------------------------------
  // read back
  // ----------------------------------------
  // reserved and unmapped bits read zero; see [RULE_14]
  logic [31:0] rd_nxt;
  logic [31:0] rdata_r;
  logic ack_r;

  always_comb
  begin
    rd_nxt = '0;
    unique case (a)
      dat_pkg::OFS_DBG_AUTH: rd_nxt[2:0] = auth_r;
      dat_pkg::OFS_TRIG_U0: rd_nxt[15:0] = gen_r[0];
      dat_pkg::OFS_TRIG_U1: rd_nxt[15:0] = gen_r[1];
      dat_pkg::OFS_TRIG_GRP: rd_nxt[15:0] = gen_r[2];
      dat_pkg::OFS_WDOG_MGMT: rd_nxt[15:8] = wm_r;
      dat_pkg::OFS_WDOG_SYS: rd_nxt[15:8] = ws_r;
      dat_pkg::OFS_DBG_EXP: rd_nxt = {exp2_r, exp1_r};
      dat_pkg::OFS_SER_PWR: rd_nxt = ser_rd;
      dat_pkg::OFS_COH_PWR: rd_nxt = coh_rd;
      default: rd_nxt = '0;
    endcase
  end

  // one-cycle registered answer to read or write
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rdata_r <= '0;
      ack_r <= 1'b0;
    end
    else
    begin
      rdata_r <= reg_req.rd ? rd_nxt : '0;
      ack_r <= reg_req.rd | reg_req.wr;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_ack = ack_r;

endmodule : dat_regs

`default_nettype wire

// >>> dat_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// register bank port checks
// ----------------------------------------
module dat_regs_properties
#(
  parameter int unsigned NUM_GEN = 3
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register access
  input wire dat_pkg::dat_req_type reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  // driven fields
  input wire dat_pkg::dat_auth_type auth_en,
  input wire dat_pkg::dat_trig_sel_type [NUM_GEN-1:0] gen_trig_sel,
  input wire logic [7:0] mgmt_wdog_debug_enable_select,
  input wire logic [7:0] unit_one_debug_enable_select,
  input wire logic [7:0] unit_one_noninvasive_select,
  input wire logic [7:0] unit_two_debug_enable_select,
  input wire logic [7:0] unit_two_noninvasive_select,
  // link power
  input wire logic serial_power_up_request,
  input wire logic serial_power_up_acknowledge,
  input wire logic coherent_power_up_request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic wr = reg_req.wr;
  wire logic rd = reg_req.rd;
  wire logic [5:0] ad = reg_req.addr;
  wire logic [31:0] wd = reg_req.wdata;
  a_ack_after_access:
    assert property ((rd || wr) |=> reg_ack) else $error("no ack");
  a_auth_write_drives:
    assert property (wr && ad == 6'h00 |=> auth_en == $past(wd[2:0]))
    else $error("auth enables wrong");
  a_trig_write_drives:
    assert property (wr && ad == 6'h04 |=> gen_trig_sel[0] == $past(wd[15:0]))
    else $error("trigger selects wrong");
  a_wdog_read_layout:
    assert property (rd && ad == 6'h10 |=> reg_rdata ==
      {16'h0000, $past(mgmt_wdog_debug_enable_select), 8'h00})
    else $error("watchdog readback wrong");
  a_exp_write_drives:
    assert property (wr && ad == 6'h18 |=> {unit_two_debug_enable_select,
      unit_two_noninvasive_select, unit_one_debug_enable_select,
      unit_one_noninvasive_select} == $past(wd))
    else $error("expansion selects wrong");
  a_serial_req_write:
    assert property (wr && ad == 6'h1C |=>
      serial_power_up_request == $past(wd[0])) else $error("serial request");
  a_coh_req_write:
    assert property (wr && ad == 6'h20 |=>
      coherent_power_up_request == $past(wd[0])) else $error("coh request");
  a_req_holds:
    assert property (!sys_rst && !(wr && ad == 6'h1C) |=>
      $stable(serial_power_up_request)) else $error("request moved");
  a_ack_readback:
    assert property (rd && ad == 6'h1C && !$past(sys_rst) |=> reg_rdata ==
      {30'h0, $past(serial_power_up_acknowledge, 2),
      $past(serial_power_up_request)}) else $error("power readback wrong");
  a_rdata_quiet:
    assert property (!rd |=> reg_rdata == 32'h0) else $error("stray rdata");
  a_unmapped_zero:
    assert property (rd && ad > 6'h20 |=> reg_rdata == 32'h0)
    else $error("unmapped read nonzero");
endmodule : dat_regs_properties
bind dat_regs dat_regs_properties #(.NUM_GEN(NUM_GEN)) dat_regs_properties_i
(
  .mclk, .sys_rst, .reg_req, .reg_rdata, .reg_ack, .auth_en, .gen_trig_sel,
  .mgmt_wdog_debug_enable_select, .unit_one_debug_enable_select,
  .unit_one_noninvasive_select, .unit_two_debug_enable_select,
  .unit_two_noninvasive_select, .serial_power_up_request,
  .serial_power_up_acknowledge, .coherent_power_up_request
);
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// register bank bench
// ----------------------------------------
module testbench;
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] rst;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } dat_row_type;
  localparam dat_row_type ROWS [12] = '{
    '{6'h00, 32'h7, 32'hFFFFFFFF, 32'h7}, '{6'h04, 32'h0, 32'hABCD1234, 32'h1234},
    '{6'h08, 32'h0, 32'h5A5AA55A, 32'hA55A}, '{6'h0C, 32'h0, 32'hFF01, 32'hFF01},
    '{6'h10, 32'h0, 32'hFFFFFFFF, 32'hFF00}, '{6'h14, 32'h0, 32'h12348001, 32'h8000},
    '{6'h18, 32'h0, 32'hDEADBEEF, 32'hDEADBEEF}, '{6'h1C, 32'h0, 32'hFFFFFFFF, 32'h1},
    '{6'h20, 32'h0, 32'h3, 32'h1}, '{6'h24, 32'h0, 32'hFFFFFFFF, 32'h0},
    '{6'h00, 32'h7, 32'h5, 32'h5}, '{6'h1C, 32'h0, 32'h2, 32'h0}};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic slow = 1'b0;
  dat_pkg::dat_req_type reg_req = '0;
  logic [31:0] reg_rdata;
  logic reg_ack;
  dat_pkg::dat_auth_type auth_en;
  dat_pkg::dat_trig_sel_type [2:0] gen_sel;
  logic [7:0] mw, sw, u1d, u1n, u2d, u2n;
  wire logic [1:0] pwr_req, pwr_ack;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #50 mclk = ~mclk;
  dat_regs #(.NUM_GEN(3)) dat_regs_i (.mclk(mclk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .auth_en(auth_en), .gen_trig_sel(gen_sel),
    .mgmt_wdog_debug_enable_select(mw), .sys_wdog_debug_enable_select(sw),
    .unit_one_debug_enable_select(u1d), .unit_one_noninvasive_select(u1n),
    .unit_two_debug_enable_select(u2d), .unit_two_noninvasive_select(u2n),
    .serial_power_up_request(pwr_req[0]),
    .serial_power_up_acknowledge(pwr_ack[0]),
    .coherent_power_up_request(pwr_req[1]),
    .coherent_power_up_acknowledge(pwr_ack[1]));
  for (genvar g = 0; g < 2; g++)
  begin : link
    dat_link_pwr_model dat_link_pwr_model_i (.mclk(mclk), .sys_rst(sys_rst),
      .slow(slow), .power_up_request(pwr_req[g]),
      .power_up_acknowledge(pwr_ack[g]));
  end
  function automatic logic [31:0] out_view(input logic [5:0] a);
    case (a)
      6'h00: out_view = {29'h0, auth_en};
      6'h04: out_view = {16'h0, gen_sel[0]};
      6'h08: out_view = {16'h0, gen_sel[1]};
      6'h0C: out_view = {16'h0, gen_sel[2]};
      6'h10: out_view = {16'h0, mw, 8'h0};
      6'h14: out_view = {16'h0, sw, 8'h0};
      6'h18: out_view = {u2d, u2n, u1d, u1n};
      6'h1C: out_view = {31'h0, pwr_req[0]};
      6'h20: out_view = {31'h0, pwr_req[1]};
      default: out_view = 32'h0;
    endcase
  endfunction : out_view
  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic access(input logic r, w, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    reg_req <= '{r, w, a, d};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    check("ack", 32'h1, {31'h0, reg_ack});
    q = reg_rdata;
  endtask : access
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // cut a hang short; the run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    logic [31:0] q, m;
    logic [5:0] a;
    int n;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (ROWS[i])
    begin
      access(1'b1, 1'b0, ROWS[i].addr, 32'h0, q);
      check("reset value", ROWS[i].rst, q);
    end
    foreach (ROWS[i])
    begin
      access(1'b0, 1'b1, ROWS[i].addr, ROWS[i].wdata, q);
      access(1'b1, 1'b0, ROWS[i].addr, 32'h0, q);
      m = (ROWS[i].addr >= 6'h1C) ? 32'hFFFFFFFD : 32'hFFFFFFFF;
      check("readback", ROWS[i].rexp, q & m);
      check("outputs", ROWS[i].rexp & m, out_view(ROWS[i].addr));
    end
    // the ack bit must ignore the write and follow the link only
    for (int k = 0; k < 2; k++)
    begin
      a = k ? 6'h20 : 6'h1C;
      slow <= (k == 0);
      // drop any request left by the row pass so the ack starts low
      access(1'b0, 1'b1, a, 32'h0, q);
      access(1'b0, 1'b1, a, 32'h3, q);
      access(1'b1, 1'b0, a, 32'h0, q);
      check("ack before settle", 32'h1, q);
      n = 0;
      while (q[1] !== 1'b1 && n < 20)
      begin
        access(1'b1, 1'b0, a, 32'h0, q);
        n++;
      end
      check("power ack", 32'h3, q);
    end
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b1, 6'h04, 32'h1111};
    @(posedge mclk);
    reg_req <= '{1'b1, 1'b1, 6'h04, 32'h2222};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    check("old value read", 32'h1111, reg_rdata);
    check("b2b write", 32'h2222, out_view(6'h04));
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    foreach (ROWS[i])
      check("reset out", ROWS[i].rst, out_view(ROWS[i].addr));
    finish_test();
  end
endmodule : testbench
`default_nettype wire
